/* src/bcd_pkg.sv */
// Package: register map, field positions, reset values, timer counts and carrier types
package bcd_pkg;

    // Register byte offsets
    localparam logic [7:0] BCD_CTRL_OFS = 8'h3c;
    localparam logic [7:0] BCD_SSID_OFS = 8'h40;

    // Bridge control field positions, relative to bit 16 of the dword
    localparam int BCD_CTRL_BASE   = 16;
    localparam int BCD_B_VGA       = 19 - BCD_CTRL_BASE;
    localparam int BCD_B_MA_MODE   = 21 - BCD_CTRL_BASE;
    localparam int BCD_B_SEC_RST   = 22 - BCD_CTRL_BASE;
    localparam int BCD_B_FBB       = 23 - BCD_CTRL_BASE;
    localparam int BCD_B_PRI_SHORT = 24 - BCD_CTRL_BASE;
    localparam int BCD_B_SEC_SHORT = 25 - BCD_CTRL_BASE;
    localparam int BCD_B_TO_STS    = 26 - BCD_CTRL_BASE;
    localparam int BCD_B_DT_SERR   = 27 - BCD_CTRL_BASE;

    // Writable and write-one-to-clear masks, reserved bits excluded
    localparam logic [15:0] BCD_CTRL_RW_MASK  = 16'h0be8;
    localparam logic [15:0] BCD_CTRL_W1C_MASK = 16'h0400;

    // Reset values
    localparam logic [15:0] BCD_CTRL_RST = 16'h0000;
    localparam logic [31:0] BCD_SSID_RST = 32'h0000_0000;
    localparam logic [31:0] BCD_ALL_ONES = 32'hffff_ffff;

    // Discard timer limits in PCI clocks
    localparam int BCD_DT_LONG_CYC  = 1 << 15;
    localparam int BCD_DT_SHORT_CYC = 1 << 10;
    localparam int BCD_DT_CNT_W     = 16;

    // Delayed request events of one side
    typedef struct packed {
        logic queued;
        logic repeated;
    } bcd_dly_ev_t;

    // Answer to a master abort seen by the bridge as initiator
    typedef struct packed {
        logic rd_all_ones;
        logic drop_write;
        logic tgt_abort;
    } bcd_ma_resp_t;

endpackage

/* src/bcd_discard_timer.sv */
// Discard timer for delayed requests on one side of the bridge
module bcd_discard_timer
    import bcd_pkg::*;
#(
    parameter int LONG_CYC  = BCD_DT_LONG_CYC,
    parameter int SHORT_CYC = BCD_DT_SHORT_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control and events
    input  wire logic        short_sel,
    input  wire bcd_dly_ev_t ev,
    // Expiry
    output logic             expire_r
);

    logic [BCD_DT_CNT_W-1:0] cnt_r;
    logic                    run_r;
    logic                    lim_short_r;

    // Limit is latched at queue time so a later write cannot shorten a running wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r       <= '0;
            run_r       <= 1'b0;
            lim_short_r <= 1'b0;
            expire_r    <= 1'b0;
        end else begin
            expire_r <= 1'b0;
            if (ev.queued) begin
                cnt_r       <= short_sel ? BCD_DT_CNT_W'(SHORT_CYC) : BCD_DT_CNT_W'(LONG_CYC);
                run_r       <= 1'b1;
                lim_short_r <= short_sel;
            end else if (ev.repeated) begin
                run_r <= 1'b0;
            end else if (run_r) begin
                if (cnt_r == BCD_DT_CNT_W'(1)) begin
                    run_r    <= 1'b0;
                    expire_r <= 1'b1;
                end
                cnt_r <= cnt_r - BCD_DT_CNT_W'(1);
            end
        end
    end

    // Helper: cycles since the request was queued
    logic [BCD_DT_CNT_W:0] age_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= '0;
        end else if (ev.queued) begin
            age_r <= '0;
        end else if (run_r) begin
            age_r <= age_r + (BCD_DT_CNT_W+1)'(1);
        end
    end

    a_expire_limit: assert property (@(posedge pclk) disable iff (!presetn)
        expire_r |-> (age_r == (lim_short_r ? (BCD_DT_CNT_W+1)'(SHORT_CYC) : (BCD_DT_CNT_W+1)'(LONG_CYC))))
        else $error("Discard timer expired at wrong count");

endmodule

/* src/bcd_top.sv */
// Bridge control upper half, subsystem ids and discard timers behind APB
//
// Our own choice: the APB interface to the registers.
module bcd_top
    import bcd_pkg::*;
#(
    parameter int LONG_CYC  = BCD_DT_LONG_CYC,
    parameter int SHORT_CYC = BCD_DT_SHORT_CYC
) (
    // APB clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready_r,
    output logic [31:0]            prdata_r,
    output logic                   pslverr_r,
    // Delayed request events, index 0 primary, 1 secondary
    input  wire bcd_dly_ev_t [1:0] dly_ev,
    output logic [1:0]             dly_discard_r,
    // Master abort seen as initiator
    input  wire logic              ma_event,
    input  wire logic              ma_is_read,
    input  wire logic              ma_ta_possible,
    input  wire logic              serr_enable,
    output bcd_ma_resp_t           ma_resp_r,
    // Decode and bus controls
    input  wire logic              vga_addr_hit,
    output logic                   vga_forward_r,
    output logic                   sec_bus_reset_n_r,
    output logic                   sec_fbb_enable_r,
    output logic                   primary_system_error_n_r
);

    logic [15:0] ctrl_r;
    logic [31:0] ssid_r;
    logic [1:0]  expire;

    // APB decode
    logic setup_ph;
    logic access_ph;
    logic wr_ctrl;
    logic wr_ssid;
    logic hit_ctrl;
    logic hit_ssid;
    logic [31:0] wmask;

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable && pready_r;
    assign hit_ctrl  = (paddr == BCD_CTRL_OFS);
    assign hit_ssid  = (paddr == BCD_SSID_OFS);
    assign wr_ctrl   = access_ph && pwrite && hit_ctrl;
    assign wr_ssid   = access_ph && pwrite && hit_ssid;
    assign wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // One wait-free access: answer registered during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= setup_ph && !hit_ctrl && !hit_ssid;
        end
    end

    // Low half of the control dword belongs to other logic and reads zero here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup_ph && !pwrite) begin
            if (hit_ctrl) begin
                prdata_r <= {ctrl_r & (BCD_CTRL_RW_MASK | BCD_CTRL_W1C_MASK), 16'h0000};
            end else if (hit_ssid) begin
                prdata_r <= ssid_r;
            end else begin
                prdata_r <= '0;
            end
        end
    end

    // Control bits writable by software
    logic [15:0] ctrl_wm;
    assign ctrl_wm = wmask[31:16] & BCD_CTRL_RW_MASK;

    // Timeout status: a new expiry in the clearing cycle wins
    logic sts_clr;
    assign sts_clr = wr_ctrl && pstrb[3] && pwdata[BCD_CTRL_BASE+BCD_B_TO_STS];

    // One process owns the whole register; reserved bits never see the write mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= BCD_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= (ctrl_r & ~ctrl_wm) | (pwdata[31:BCD_CTRL_BASE] & ctrl_wm);
            end
            if (|expire) begin
                ctrl_r[BCD_B_TO_STS] <= 1'b1;
            end else if (sts_clr) begin
                ctrl_r[BCD_B_TO_STS] <= 1'b0;
            end
        end
    end

    // Subsystem ids, byte-lane writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ssid_r <= BCD_SSID_RST;
        end else if (wr_ssid) begin
            ssid_r[15:0]  <= (ssid_r[15:0] & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            ssid_r[31:16] <= (ssid_r[31:16] & ~wmask[31:16]) | (pwdata[31:16] & wmask[31:16]);
        end
    end

    // Discard timers, one per side
    logic [1:0] short_sel;
    assign short_sel = {ctrl_r[BCD_B_SEC_SHORT], ctrl_r[BCD_B_PRI_SHORT]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dt
            bcd_discard_timer #(
                .LONG_CYC  (LONG_CYC),
                .SHORT_CYC (SHORT_CYC)
            ) u_dt (
                .pclk      (pclk),
                .presetn   (presetn),
                .short_sel (short_sel[gi]),
                .ev        (dly_ev[gi]),
                .expire_r  (expire[gi])
            );
        end
    endgenerate

    // Tells the buffer logic to flush the request and its completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_discard_r <= 2'b00;
        end else begin
            dly_discard_r <= expire;
        end
    end

    // Bus controls follow the register with one flop of delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vga_forward_r     <= 1'b0;
            sec_bus_reset_n_r <= 1'b1;
            sec_fbb_enable_r  <= 1'b0;
        end else begin
            vga_forward_r     <= vga_addr_hit && ctrl_r[BCD_B_VGA];
            sec_bus_reset_n_r <= !ctrl_r[BCD_B_SEC_RST];
            sec_fbb_enable_r  <= ctrl_r[BCD_B_FBB];
        end
    end

    // Master abort answer, one-cycle pulses
    logic ma_report;
    assign ma_report = ma_event && ctrl_r[BCD_B_MA_MODE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ma_resp_r <= '0;
        end else begin
            ma_resp_r.rd_all_ones <= ma_event && !ctrl_r[BCD_B_MA_MODE] && ma_is_read;
            ma_resp_r.drop_write  <= ma_event && !ctrl_r[BCD_B_MA_MODE] && !ma_is_read;
            ma_resp_r.tgt_abort   <= ma_report && ma_ta_possible;
        end
    end

    // System error: one-cycle low pulse per cycle with a cause; causes in the same cycle share one pulse
    logic serr_ma;
    logic serr_dt;
    assign serr_ma = ma_report && !ma_ta_possible && serr_enable;
    assign serr_dt = (|expire) && ctrl_r[BCD_B_DT_SERR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_system_error_n_r <= 1'b1;
        end else begin
            primary_system_error_n_r <= !(serr_ma || serr_dt);
        end
    end

    // Rule checks, sampled one flop after their cause, except the reserved-bit state check, which holds every cycle
    a_vga_forward: assert property (@(posedge pclk) disable iff (!presetn)
        vga_forward_r == $past(vga_addr_hit && ctrl_r[BCD_B_VGA]))
        else $error("VGA forward does not follow enable");

    a_ma_hidden: assert property (@(posedge pclk) disable iff (!presetn)
        (ma_event && !ctrl_r[BCD_B_MA_MODE])
        |=> (ma_resp_r.rd_all_ones == $past(ma_is_read)) && !ma_resp_r.tgt_abort && primary_system_error_n_r
            || $past(serr_dt))
        else $error("Hidden master abort answered wrongly");

    a_ma_report: assert property (@(posedge pclk) disable iff (!presetn)
        (ma_event && ctrl_r[BCD_B_MA_MODE] && !ma_ta_possible && serr_enable)
        |=> !primary_system_error_n_r && !ma_resp_r.tgt_abort)
        else $error("Reported master abort did not raise system error");

    a_sec_reset: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[BCD_B_SEC_RST] ##1 ctrl_r[BCD_B_SEC_RST] |-> !sec_bus_reset_n_r)
        else $error("Secondary reset not held");

    a_fbb_gate: assert property (@(posedge pclk) disable iff (!presetn)
        sec_fbb_enable_r |-> $past(ctrl_r[BCD_B_FBB]))
        else $error("Fast back-to-back enabled while bit clear");

    a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
        (|expire) |=> ctrl_r[BCD_B_TO_STS])
        else $error("Timeout status not set on expiry");

    a_dt_serr: assert property (@(posedge pclk) disable iff (!presetn)
        (|expire) && !serr_ma |=> (primary_system_error_n_r == !$past(ctrl_r[BCD_B_DT_SERR])))
        else $error("System error on expiry mismatches enable");

    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $past(setup_ph && !pwrite && hit_ctrl) |-> (prdata_r[31:28] == 4'h0) && !prdata_r[20])
        else $error("Reserved control bits read nonzero");

    a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (sts_clr && !(|expire)) |=> !ctrl_r[BCD_B_TO_STS])
        else $error("Timeout status not cleared by write one");

    a_w0_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r[BCD_B_TO_STS] && !sts_clr) |=> ctrl_r[BCD_B_TO_STS])
        else $error("Timeout status lost without clear");

    a_ssid_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ssid && pstrb == 4'hf) |=> ssid_r == $past(pwdata))
        else $error("Subsystem ids not written");

    a_discard_drop: assert property (@(posedge pclk) disable iff (!presetn)
        expire[0] |=> dly_discard_r[0] ##1 !dly_discard_r[0] || expire[0])
        else $error("Discard not signalled on expiry");

    a_discard_sec: assert property (@(posedge pclk) disable iff (!presetn)
        expire[1] |=> dly_discard_r[1])
        else $error("Secondary discard not signalled on expiry");

    a_vga_block: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r[BCD_B_VGA] |=> !vga_forward_r)
        else $error("VGA forwarded while disabled");

    a_sec_release: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r[BCD_B_SEC_RST] |=> sec_bus_reset_n_r)
        else $error("Secondary reset forced while bit clear");

    a_ma_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (ma_event && !ctrl_r[BCD_B_MA_MODE] && !ma_is_read) |=> ma_resp_r.drop_write && !ma_resp_r.rd_all_ones)
        else $error("Hidden write abort not dropped");

    a_ta_report: assert property (@(posedge pclk) disable iff (!presetn)
        (ma_event && ctrl_r[BCD_B_MA_MODE] && ma_ta_possible)
        |=> ma_resp_r.tgt_abort && !ma_resp_r.drop_write && !ma_resp_r.rd_all_ones)
        else $error("Reported master abort without target abort");

    a_rsvd_state: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r & ~(BCD_CTRL_RW_MASK | BCD_CTRL_W1C_MASK)) == 16'h0000)
        else $error("Reserved control bit holds a one");

    a_ssid_keep: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_ssid |=> $stable(ssid_r))
        else $error("Subsystem ids changed without a write");

    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready_r |-> $past(setup_ph))
        else $error("Ready without a preceding setup cycle");

    // Main scenarios
    c_expire_pri: cover property (@(posedge pclk) disable iff (!presetn) expire[0]);
    c_expire_sec: cover property (@(posedge pclk) disable iff (!presetn) expire[1]);
    c_ma_ta: cover property (@(posedge pclk) disable iff (!presetn) ma_resp_r.tgt_abort);
    c_sts_race: cover property (@(posedge pclk) disable iff (!presetn) sts_clr && (|expire));
    c_dt_serr: cover property (@(posedge pclk) disable iff (!presetn) (|expire) && ctrl_r[BCD_B_DT_SERR]);

endmodule

/* verif/bcd_initiator_model.sv */
// Stand-in for the PCI initiators: delayed request and master abort events
module bcd_initiator_model
    import bcd_pkg::*;
(
    // Clock
    input  wire logic         pclk,
    // Events and levels toward the bridge
    output bcd_dly_ev_t [1:0] dly_ev,
    output logic              ma_event,
    output logic              ma_is_read,
    output logic              ma_ta_possible,
    output logic              serr_enable,
    output logic              vga_addr_hit
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        dly_ev = '0;
        ma_event = 1'b0;
        ma_is_read = 1'b0;
        ma_ta_possible = 1'b0;
        serr_enable = 1'b0;
        vga_addr_hit = 1'b0;
    end

    // One-cycle pulse; returns at the edge that samples it
    task automatic pulse_ev(input int side, input logic rep);
        @(posedge pclk);
        if (rep) begin
            dly_ev[side].repeated <= 1'b1;
        end else begin
            dly_ev[side].queued <= 1'b1;
        end
        @(posedge pclk);
        dly_ev <= '0;
    endtask

    // Qualifiers are left standing afterwards, as a real initiator may
    task automatic abort(input logic rd, input logic ta, input logic se);
        @(posedge pclk);
        ma_event <= 1'b1;
        ma_is_read <= rd;
        ma_ta_possible <= ta;
        serr_enable <= se;
        @(posedge pclk);
        ma_event <= 1'b0;
    endtask

    task automatic set_vga(input logic hit);
        @(posedge pclk);
        vga_addr_hit <= hit;
    endtask
endmodule

/* verif/test_bridge_control_discard_timers.sv */
// Self-checking bench for the bridge control upper half and discard timers
module test_bridge_control_discard_timers;
    timeunit 1ns;
    timeprecision 100ps;
    import bcd_pkg::*;

    localparam int LNG = 64;
    localparam int SHT = 8;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [3:0]        pstrb = 4'h0;
    logic              pready_r;
    logic [31:0]       prdata_r;
    logic              pslverr_r;
    bcd_dly_ev_t [1:0] dly_ev;
    logic [1:0]        dly_discard_r;
    logic              ma_event;
    logic              ma_is_read;
    logic              ma_ta_possible;
    logic              serr_enable;
    bcd_ma_resp_t      ma_resp_r;
    logic              vga_addr_hit;
    logic              vga_forward_r;
    logic              sec_bus_reset_n_r;
    logic              sec_fbb_enable_r;
    logic              primary_system_error_n_r;
    int                num_errors = 0;
    int                check_count = 0;
    int                cycles = 0;

    always #25 pclk = ~pclk;

    bcd_top #(.LONG_CYC(LNG), .SHORT_CYC(SHT)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready_r(pready_r), .prdata_r(prdata_r),
        .pslverr_r(pslverr_r), .dly_ev(dly_ev), .dly_discard_r(dly_discard_r), .ma_event(ma_event),
        .ma_is_read(ma_is_read), .ma_ta_possible(ma_ta_possible), .serr_enable(serr_enable),
        .ma_resp_r(ma_resp_r), .vga_addr_hit(vga_addr_hit), .vga_forward_r(vga_forward_r),
        .sec_bus_reset_n_r(sec_bus_reset_n_r), .sec_fbb_enable_r(sec_fbb_enable_r),
        .primary_system_error_n_r(primary_system_error_n_r));

    bcd_initiator_model u_init (
        .pclk(pclk), .dly_ev(dly_ev), .ma_event(ma_event), .ma_is_read(ma_is_read),
        .ma_ta_possible(ma_ta_possible), .serr_enable(serr_enable), .vga_addr_hit(vga_addr_hit));

    task automatic complete_run();
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Run is well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        int to;
        to = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            to++;
        end while (pready_r !== 1'b1 && to < 50);
        if (pready_r !== 1'b1) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready_r, 1'b1);
            num_errors++;
        end
        rd = prdata_r;
        err = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, s, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, exp_err});
    endtask

    // Edges counted from the one that samples the queued pulse
    task automatic wait_discard(input int side, input int max, output int n, output logic s);
        int k;
        n = 0;
        s = 1'bx;
        for (k = 1; k <= max && n == 0; k++) begin
            @(posedge pclk);
            #1;
            if (dly_discard_r[side] === 1'b1) begin
                n = k;
                s = primary_system_error_n_r;
            end
        end
    endtask

    logic [31:0] ctl;
    logic        s;
    int          n;
    int          i;
    logic [4:0]  ma_tab [5];
    logic [3:0]  ma_exp [5];

    initial begin
        ma_tab = '{5'b10100, 5'b10000, 5'b11010, 5'b11001, 5'b11000};
        ma_exp = '{4'b1001, 4'b0101, 4'b0011, 4'b0000, 4'b0001};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk({sec_bus_reset_n_r, primary_system_error_n_r, vga_forward_r, sec_fbb_enable_r}, 4'hc);
        rd_chk(8'h3c, 32'h0000_0000, 1'b0);
        rd_chk(8'h40, 32'h0000_0000, 1'b0);
        u_init.set_vga(1'b1);
        wr(8'h3c, 32'hffff_ffff, 4'hf);
        rd_chk(8'h3c, 32'h0be8_0000, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        chk({vga_forward_r, sec_bus_reset_n_r, sec_fbb_enable_r}, 3'b101);
        wr(8'h3c, 32'h0000_0000, 4'hf);
        repeat (2) @(posedge pclk);
        #1;
        chk({vga_forward_r, sec_bus_reset_n_r, sec_fbb_enable_r}, 3'b010);
        wr(8'h40, 32'h1234_abcd, 4'hf);
        rd_chk(8'h40, 32'h1234_abcd, 1'b0);
        wr(8'h40, 32'hffff_5678, 4'h3);
        rd_chk(8'h40, 32'h1234_5678, 1'b0);
        rd_chk(8'h44, 32'h0000_0000, 1'b1);
        // Master abort, low four bits: mode, read, target abort possible, serr enable
        for (i = 0; i < 5; i++) begin
            wr(8'h3c, {10'h0, ma_tab[i][3], 21'h0}, 4'hf);
            u_init.abort(ma_tab[i][2], ma_tab[i][1], ma_tab[i][0]);
            #1;
            chk({ma_resp_r, primary_system_error_n_r}, ma_exp[i]);
        end
        // Each side with long and short limit; system error enabled with short
        for (i = 0; i < 4; i++) begin
            ctl = (i % 2) ? (32'h0800_0000 | (32'h0100_0000 << (i / 2))) : 32'h0000_0000;
            wr(8'h3c, ctl, 4'hf);
            u_init.pulse_ev(i / 2, 1'b0);
            wait_discard(i / 2, 200, n, s);
            chk(n, (i % 2) ? SHT + 1 : LNG + 1);
            chk({31'h0, s}, {31'h0, ~ctl[27]});
            rd_chk(8'h3c, ctl | 32'h0400_0000, 1'b0);
            wr(8'h3c, ctl, 4'hf);
            rd_chk(8'h3c, ctl | 32'h0400_0000, 1'b0);
            wr(8'h3c, ctl | 32'h0400_0000, 4'hf);
            rd_chk(8'h3c, ctl, 1'b0);
        end
        // A repeat in time stops the timer
        wr(8'h3c, 32'h0000_0000, 4'hf);
        u_init.pulse_ev(1, 1'b0);
        u_init.pulse_ev(1, 1'b1);
        wait_discard(1, 100, n, s);
        chk(n, 0);
        rd_chk(8'h3c, 32'h0000_0000, 1'b0);
        complete_run();
    end
endmodule
